// >>> logic/mie_change_det.sv
/*
 * mie_change_det: per-bit change and falling-edge detector.
 * assumes: inputs synchronous to aclk; the first sample after reset only
 * arms the detector so no spurious event appears.
 */
`timescale 1ns/1ps
module mie_change_det #(
   parameter int W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] level,
   output logic [W-1:0] changed,
   output logic [W-1:0] fell
);
   logic [W-1:0] prev_reg;
   logic [W-1:0] prev_next;
   logic armed_reg;
   logic armed_next;

   always_comb begin
      prev_next = level;
      armed_next = 1'b1;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_reg <= '0;
         armed_reg <= 1'b0;
      end else begin
         prev_reg <= prev_next;
         armed_reg <= armed_next;
      end
   end

   assign changed = armed_reg ? (prev_reg ^ level) : '0;
   assign fell = armed_reg ? (prev_reg & ~level) : '0;
endmodule

// >>> logic/mie_irq_mask.sv
/*
 * mie_irq_mask: first interrupt enable mask of the metering core, with
 * its event status, pulse mode and accumulation mode registers on AXI4-Lite.
 * assumes: datapath events synchronous to aclk; one master on the bus.
 */
// Function
// - enable bit 0: interrupt on bit 30 change of any total active energy
// - enable bit 1: fundamental active bit 30 change; inert without fundamental
// - enable bit 2: total reactive bit 30 change; inert without reactive
// - enable bit 3: fundamental reactive bit 30 change; inert without fundamental
// - enable bit 4: bit 30 change of any apparent energy accumulator
// - enable bit 5: interrupt when line-cycle accumulation finishes
// - enable bits 6-8: phase active power sign change, source by mode bit 6
// - enable bits 10-12: phase reactive sign change, source by mode bit 7
// - enable bits 9, 13, 18: summed power sign change in paths 1-3
// - enable bits 14-16: falling edge of calibration pulse one to three
// - pulse interrupts still raised while the pulse output is disabled
// - each pulse output uses power type from its 3-bit selector field
// - enable bit 17: interrupt when the periodic processing pass completes
// - mask at index E50A; bits 31 to 19 reserved, read zero
// - reset-complete interrupt cannot be masked
`timescale 1ns/1ps
module mie_irq_mask
   import mie_pkg::*;
#(
   parameter bit HAS_FUND = 1'b1,
   parameter bit HAS_REACT = 1'b1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [mie_pkg::MIE_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [mie_pkg::MIE_DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [mie_pkg::MIE_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [mie_pkg::MIE_DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire mie_pkg::mie_events_t events,
   output mie_pkg::mie_pulse_cfg_t pulse_cfg,
   output logic cal_pulse_out_one,
   output logic cal_pulse_out_two,
   output logic cal_pulse_out_three,
   output logic irq,
   output logic irq_pin_first_n
);
   import mie_pkg::*;

   localparam logic [MIE_ADDR_W-1:0] ADDR_ENABLE = {2'h0, MIE_IDX_IRQ_ENABLE_FIRST, 2'h0};
   localparam logic [MIE_ADDR_W-1:0] ADDR_STATUS = {2'h0, MIE_IDX_EVENT_STATUS, 2'h0};
   localparam logic [MIE_ADDR_W-1:0] ADDR_PULSE = {2'h0, MIE_IDX_PULSE_MODE, 2'h0};
   localparam logic [MIE_ADDR_W-1:0] ADDR_ACCUM = {2'h0, MIE_IDX_ACCUM_MODE, 2'h0};
   localparam int DET_W = 27;

   typedef enum logic [2:0] {
      MIE_SEL_NONE = 3'b000,
      MIE_SEL_ENABLE = 3'b001,
      MIE_SEL_STATUS = 3'b010,
      MIE_SEL_PULSE = 3'b011,
      MIE_SEL_ACCUM = 3'b100
   } mie_sel_t;

   function automatic mie_sel_t decode(input logic [MIE_ADDR_W-1:0] addr);
      mie_sel_t sel;
      case ({addr[MIE_ADDR_W-1:2], 2'h0})
         ADDR_ENABLE: sel = MIE_SEL_ENABLE;
         ADDR_STATUS: sel = MIE_SEL_STATUS;
         ADDR_PULSE: sel = MIE_SEL_PULSE;
         ADDR_ACCUM: sel = MIE_SEL_ACCUM;
         default: sel = MIE_SEL_NONE;
      endcase
      return sel;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return res;
   endfunction

   // bus state
   logic aw_hold_reg, aw_hold_next;
   logic [MIE_ADDR_W-1:0] aw_addr_reg, aw_addr_next;
   logic w_hold_reg, w_hold_next;
   logic [31:0] w_data_reg, w_data_next;
   logic [3:0] w_strb_reg, w_strb_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;

   // register file
   logic [MIE_EN_W-1:0] enable_reg, enable_next;
   logic [31:0] status_reg, status_next;
   logic [MIE_PULSE_MODE_W-1:0] pulse_mode_reg, pulse_mode_next;
   logic [1:0] accum_mode_reg, accum_mode_next;
   logic rst_seen_reg, rst_seen_next;
   logic irq_reg, irq_next;
   logic [2:0] pulse_out_reg, pulse_out_next;

   logic wr_go;
   mie_sel_t wr_sel;
   mie_sel_t rd_sel;
   logic [31:0] wr_val;
   logic [MIE_EN_W-1:0] feature_mask;
   logic [MIE_EN_W-1:0] eff_enable;
   logic [31:0] ev_set;
   logic [DET_W-1:0] det_level;
   logic [DET_W-1:0] det_changed;
   logic [DET_W-1:0] det_fell;
   logic [2:0] act_sign;
   logic [2:0] react_sign;

   // sign source switching may itself look like a sign change; software
   // should clear the status after changing the source selectors
   assign act_sign = accum_mode_reg[0] ? events.fund_act_sign : events.tot_act_sign;
   assign react_sign = accum_mode_reg[1] ? events.fund_react_sign
                                         : events.tot_react_sign;

   assign det_level = {events.cal_pulse_raw_n, events.path_sum_sign, react_sign, act_sign,
                       events.apparent_bit30, events.fund_react_bit30,
                       events.tot_react_bit30, events.fund_act_bit30, events.tot_act_bit30};

   mie_change_det #(
      .W(DET_W)
   ) u_det (
      .aclk(aclk),
      .aresetn(aresetn),
      .level(det_level),
      .changed(det_changed),
      .fell(det_fell)
   );

   always_comb begin
      ev_set = '0;
      ev_set[MIE_B_TOT_ACT_HALF] = |det_changed[2:0];
      ev_set[MIE_B_FUND_ACT_HALF] = |det_changed[5:3];
      ev_set[MIE_B_TOT_REACT_HALF] = |det_changed[8:6];
      ev_set[MIE_B_FUND_REACT_HALF] = |det_changed[11:9];
      ev_set[MIE_B_APPARENT_HALF] = |det_changed[14:12];
      ev_set[MIE_B_LINE_CYCLE_DONE] = events.line_cycle_done;
      ev_set[MIE_B_PHASE_A_ACT_SIGN +: 3] = det_changed[17:15];
      ev_set[MIE_B_PHASE_A_REACT_SIGN +: 3] = det_changed[20:18];
      ev_set[MIE_B_PATH1_SUM_SIGN] = det_changed[21];
      ev_set[MIE_B_PATH2_SUM_SIGN] = det_changed[22];
      ev_set[MIE_B_PATH3_SUM_SIGN] = det_changed[23];
      // taken from the raw pulse, ahead of the disable gate
      ev_set[MIE_B_CAL_PULSE_ONE +: 3] = det_fell[26:24];
      ev_set[MIE_B_DSP_PASS_DONE] = events.dsp_pass_done;
      ev_set[MIE_B_RESET_COMPLETE] = ~rst_seen_reg;
   end

   // variants without a measurement keep the bit but let it do nothing
   assign feature_mask = ~((HAS_FUND ? '0 : MIE_NEEDS_FUND) |
                           (HAS_REACT ? '0 : MIE_NEEDS_REACT));
   assign eff_enable = enable_reg & feature_mask;

   assign wr_go = aw_hold_reg & w_hold_reg & ~bvalid_reg;
   assign wr_sel = decode(aw_addr_reg);
   assign rd_sel = decode(s_axi_araddr);

   always_comb begin
      wr_val = '0;
      case (wr_sel)
         MIE_SEL_ENABLE: wr_val = merge({13'h0, enable_reg}, w_data_reg, w_strb_reg);
         MIE_SEL_PULSE: wr_val = merge({20'h0, pulse_mode_reg}, w_data_reg, w_strb_reg);
         MIE_SEL_ACCUM: wr_val = merge({24'h0, accum_mode_reg, 6'h0}, w_data_reg, w_strb_reg);
         MIE_SEL_STATUS: wr_val = merge(32'h0, w_data_reg, w_strb_reg);
         default: wr_val = '0;
      endcase
   end

   always_comb begin
      aw_hold_next = aw_hold_reg;
      aw_addr_next = aw_addr_reg;
      w_hold_next = w_hold_reg;
      w_data_next = w_data_reg;
      w_strb_next = w_strb_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_next = 1'b1;
         aw_addr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_hold_next = 1'b1;
         w_data_next = s_axi_wdata;
         w_strb_next = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
      if (wr_go) begin
         aw_hold_next = 1'b0;
         w_hold_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = (wr_sel == MIE_SEL_NONE) ? MIE_RESP_SLVERR : MIE_RESP_OKAY;
      end
      if (s_axi_rvalid && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_next = 1'b1;
         rresp_next = MIE_RESP_OKAY;
         case (rd_sel)
            MIE_SEL_ENABLE: rdata_next = {13'h0, enable_reg};
            MIE_SEL_STATUS: rdata_next = status_reg;
            MIE_SEL_PULSE: rdata_next = {20'h0, pulse_mode_reg};
            MIE_SEL_ACCUM: rdata_next = {24'h0, accum_mode_reg, 6'h0};
            default: begin
               rdata_next = '0;
               rresp_next = MIE_RESP_SLVERR;
            end
         endcase
      end
   end

   always_comb begin
      enable_next = enable_reg;
      pulse_mode_next = pulse_mode_reg;
      accum_mode_next = accum_mode_reg;
      rst_seen_next = 1'b1;
      status_next = status_reg;
      if (wr_go) begin
         case (wr_sel)
            MIE_SEL_ENABLE: enable_next = wr_val[MIE_EN_W-1:0];
            MIE_SEL_PULSE: pulse_mode_next = wr_val[MIE_PULSE_MODE_W-1:0];
            MIE_SEL_ACCUM: accum_mode_next = wr_val[MIE_B_REACTIVE_SIGN_SRC:
                                                    MIE_B_ACTIVE_SIGN_SRC];
            MIE_SEL_STATUS: status_next = status_reg & ~wr_val;
            default: enable_next = enable_reg;
         endcase
      end
      // a new event in the clearing cycle survives the clear
      status_next = status_next | ev_set;
      irq_next = (|(status_next[MIE_EN_W-1:0] & eff_enable))
                 | status_next[MIE_B_RESET_COMPLETE];
      pulse_out_next = events.cal_pulse_raw_n |
                       pulse_mode_reg[MIE_B_PULSE_ONE_DIS +: 3];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_hold_reg <= 1'b0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
         bvalid_reg <= 1'b0;
         bresp_reg <= MIE_RESP_OKAY;
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= MIE_RESP_OKAY;
         // pulse enables are undefined to software; zero is the chosen value
         enable_reg <= MIE_RST_IRQ_ENABLE_FIRST[MIE_EN_W-1:0];
         status_reg <= MIE_RST_EVENT_STATUS;
         pulse_mode_reg <= MIE_RST_PULSE_MODE[MIE_PULSE_MODE_W-1:0];
         accum_mode_reg <= MIE_RST_ACCUM_MODE[MIE_B_REACTIVE_SIGN_SRC:MIE_B_ACTIVE_SIGN_SRC];
         rst_seen_reg <= 1'b0;
         irq_reg <= 1'b0;
         pulse_out_reg <= 3'h7;
      end else begin
         aw_hold_reg <= aw_hold_next;
         aw_addr_reg <= aw_addr_next;
         w_hold_reg <= w_hold_next;
         w_data_reg <= w_data_next;
         w_strb_reg <= w_strb_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
         enable_reg <= enable_next;
         status_reg <= status_next;
         pulse_mode_reg <= pulse_mode_next;
         accum_mode_reg <= accum_mode_next;
         rst_seen_reg <= rst_seen_next;
         irq_reg <= irq_next;
         pulse_out_reg <= pulse_out_next;
      end
   end

   assign s_axi_awready = ~aw_hold_reg;
   assign s_axi_wready = ~w_hold_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = ~rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   always_comb begin
      pulse_cfg.pulse_one_power_sel = pulse_mode_reg[MIE_B_PULSE_ONE_SEL +: 3];
      pulse_cfg.pulse_two_power_sel = pulse_mode_reg[MIE_B_PULSE_TWO_SEL +: 3];
      pulse_cfg.pulse_three_power_sel = pulse_mode_reg[MIE_B_PULSE_THREE_SEL +: 3];
      pulse_cfg.active_sign_source_sel = accum_mode_reg[0];
      pulse_cfg.reactive_sign_source_sel = accum_mode_reg[1];
   end

   assign cal_pulse_out_one = pulse_out_reg[0];
   assign cal_pulse_out_two = pulse_out_reg[1];
   assign cal_pulse_out_three = pulse_out_reg[2];
   assign irq = irq_reg;
   assign irq_pin_first_n = ~irq_reg;
endmodule

// >>> logic/mie_pkg.sv
/*
 * mie_pkg: constants, register map and carrier types of the first
 * interrupt enable mask block of the energy metering core.
 * assumes: 32-bit AXI4-Lite register bus, one 50 MHz clock.
 */
package mie_pkg;

   localparam int MIE_ADDR_W = 20;
   localparam int MIE_DATA_W = 32;

   // register indices; the byte address is four times the index
   localparam logic [15:0] MIE_IDX_IRQ_ENABLE_FIRST = 16'hE50A;
   localparam logic [15:0] MIE_IDX_EVENT_STATUS = 16'hE5F0;
   localparam logic [15:0] MIE_IDX_PULSE_MODE = 16'hE5F1;
   localparam logic [15:0] MIE_IDX_ACCUM_MODE = 16'hE5F2;

   // enable / status bit positions
   localparam int MIE_B_TOT_ACT_HALF = 0;
   localparam int MIE_B_FUND_ACT_HALF = 1;
   localparam int MIE_B_TOT_REACT_HALF = 2;
   localparam int MIE_B_FUND_REACT_HALF = 3;
   localparam int MIE_B_APPARENT_HALF = 4;
   localparam int MIE_B_LINE_CYCLE_DONE = 5;
   localparam int MIE_B_PHASE_A_ACT_SIGN = 6;
   localparam int MIE_B_PATH1_SUM_SIGN = 9;
   localparam int MIE_B_PHASE_A_REACT_SIGN = 10;
   localparam int MIE_B_PATH2_SUM_SIGN = 13;
   localparam int MIE_B_CAL_PULSE_ONE = 14;
   localparam int MIE_B_DSP_PASS_DONE = 17;
   localparam int MIE_B_PATH3_SUM_SIGN = 18;
   localparam int MIE_B_RESET_COMPLETE = 31;
   localparam int MIE_EN_W = 19;

   // accumulation mode fields
   localparam int MIE_B_ACTIVE_SIGN_SRC = 6;
   localparam int MIE_B_REACTIVE_SIGN_SRC = 7;

   // pulse mode fields
   localparam int MIE_B_PULSE_ONE_SEL = 0;
   localparam int MIE_B_PULSE_TWO_SEL = 3;
   localparam int MIE_B_PULSE_THREE_SEL = 6;
   localparam int MIE_B_PULSE_ONE_DIS = 9;
   localparam int MIE_PULSE_MODE_W = 12;

   // reset values
   localparam logic [MIE_DATA_W-1:0] MIE_RST_IRQ_ENABLE_FIRST = 32'h0000_0000;
   localparam logic [MIE_DATA_W-1:0] MIE_RST_EVENT_STATUS = 32'h0000_0000;
   localparam logic [MIE_DATA_W-1:0] MIE_RST_PULSE_MODE = 32'h0000_0000;
   localparam logic [MIE_DATA_W-1:0] MIE_RST_ACCUM_MODE = 32'h0000_0000;

   // enables that need fundamental or reactive measurement
   localparam logic [MIE_EN_W-1:0] MIE_NEEDS_FUND = 19'h0000A;
   localparam logic [MIE_EN_W-1:0] MIE_NEEDS_REACT = 19'h01C04;

   localparam logic [1:0] MIE_RESP_OKAY = 2'h0;
   localparam logic [1:0] MIE_RESP_SLVERR = 2'h2;

   // levels and pulses from the metering datapath; sign bits are 1 when negative
   typedef struct packed {
      logic [2:0] tot_act_bit30;
      logic [2:0] fund_act_bit30;
      logic [2:0] tot_react_bit30;
      logic [2:0] fund_react_bit30;
      logic [2:0] apparent_bit30;
      logic [2:0] tot_act_sign;
      logic [2:0] fund_act_sign;
      logic [2:0] tot_react_sign;
      logic [2:0] fund_react_sign;
      logic [2:0] path_sum_sign;
      logic [2:0] cal_pulse_raw_n;
      logic line_cycle_done;
      logic dsp_pass_done;
   } mie_events_t;

   // pulse mode and sign source settings handed back to the pulse generators
   typedef struct packed {
      logic [2:0] pulse_three_power_sel;
      logic [2:0] pulse_two_power_sel;
      logic [2:0] pulse_one_power_sel;
      logic active_sign_source_sel;
      logic reactive_sign_source_sel;
   } mie_pulse_cfg_t;

endpackage

// >>> test/mie_irq_mask_properties.sv
/*
 * mie_irq_mask_properties: concurrent checks on the ports of mie_irq_mask.
 * assumes: single aclk domain, synchronous active-low aresetn; bound below.
 */
`timescale 1ns/1ps
module mie_irq_mask_properties
   import mie_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [mie_pkg::MIE_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [mie_pkg::MIE_DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire mie_pkg::mie_events_t events,
   input wire logic cal_pulse_out_one,
   input wire logic cal_pulse_out_two,
   input wire logic cal_pulse_out_three,
   input wire logic irq,
   input wire logic irq_pin_first_n
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // address of the read in flight, so read data can be judged per register
   logic [mie_pkg::MIE_ADDR_W-1:0] ar_q;
   always_ff @(posedge aclk) begin
      if (s_axi_arvalid && s_axi_arready) begin
         ar_q <= s_axi_araddr;
      end
   end
   property p_pin_inv; irq_pin_first_n == !irq; endproperty
   a_pin_inv: assert property (p_pin_inv) else $error("pin not inverse of irq");
   property p_rst_done; $rose(aresetn) |-> ##[0:3] irq; endproperty
   a_rst_done: assert property (p_rst_done) else $error("no irq after reset");
   property p_cal_idle; (&events.cal_pulse_raw_n) |=>
      {cal_pulse_out_three, cal_pulse_out_two, cal_pulse_out_one} == 3'h7; endproperty
   a_cal_idle: assert property (p_cal_idle) else $error("pulse out low w/o pulse");
   property p_cal_low; !cal_pulse_out_one |-> !$past(events.cal_pulse_raw_n[0]); endproperty
   a_cal_low: assert property (p_cal_low) else $error("pulse out one w/o cause");
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_b_both; $rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready);
   endproperty
   a_b_both: assert property (p_b_both) else $error("response before both parts");
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read response dropped");
   property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_r_lat: assert property (p_r_lat) else $error("read data late");
   property p_ar_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar_busy: assert property (p_ar_busy) else $error("read taken while busy");
   property p_err_zero; s_axi_rvalid && s_axi_rresp == MIE_RESP_SLVERR |-> s_axi_rdata == 32'h0;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("error read not zero");
   property p_rsvd; s_axi_rvalid && ar_q == {2'b00, MIE_IDX_IRQ_ENABLE_FIRST, 2'b00}
      |-> s_axi_rdata[31:19] == 13'h0; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved mask bits set");
endmodule

bind mie_irq_mask mie_irq_mask_properties u_props (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .events(events),
   .cal_pulse_out_one(cal_pulse_out_one), .cal_pulse_out_two(cal_pulse_out_two),
   .cal_pulse_out_three(cal_pulse_out_three), .irq(irq), .irq_pin_first_n(irq_pin_first_n));

// >>> test/testbench.sv
/*
 * testbench: register and event tests of mie_irq_mask over AXI4-Lite.
 * assumes: default feature parameters; events driven as datapath levels.
 */
`timescale 1ns/1ps
module testbench;
   import mie_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [19:0] awaddr = 20'h0, araddr = 20'h0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq, irq_n, c1, c2, c3;
   logic [1:0] bresp, rresp, r;
   mie_events_t events = '{cal_pulse_raw_n: 3'h7, default: '0};
   mie_pulse_cfg_t pulse_cfg;
   int err_total = 0;
   int tests_run = 0;
   localparam logic [19:0] EN = {2'b00, MIE_IDX_IRQ_ENABLE_FIRST, 2'b00};
   localparam logic [19:0] ST = {2'b00, MIE_IDX_EVENT_STATUS, 2'b00};
   localparam logic [19:0] PM = {2'b00, MIE_IDX_PULSE_MODE, 2'b00};
   localparam logic [19:0] AM = {2'b00, MIE_IDX_ACCUM_MODE, 2'b00};
   always #10 aclk = ~aclk;
   mie_irq_mask dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .events(events),
      .pulse_cfg(pulse_cfg), .cal_pulse_out_one(c1), .cal_pulse_out_two(c2),
      .cal_pulse_out_three(c3), .irq(irq), .irq_pin_first_n(irq_n));
   task automatic test_done;
      $display("errors %0d comparisons %0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   // address and data offered together, each released once its own ready is seen
   task automatic wr(input logic [19:0] a, input logic [31:0] v, output logic [1:0] rs);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         n++;
      end while (bvalid !== 1'b1 && n < 100);
      chk(32'(bvalid), 32'h1, "write answer");
      rs = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [19:0] a, output logic [31:0] v, output logic [1:0] rs);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         n++;
      end while (rvalid !== 1'b1 && n < 100);
      chk(32'(rvalid), 32'h1, "read answer");
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   // one datapath event of the kind that feeds enable bit b
   task automatic ev(input int b);
      @(posedge aclk);
      case (b)
         0: events.tot_act_bit30[0] <= ~events.tot_act_bit30[0];
         1: events.fund_act_bit30[1] <= ~events.fund_act_bit30[1];
         2: events.tot_react_bit30[2] <= ~events.tot_react_bit30[2];
         3: events.fund_react_bit30[0] <= ~events.fund_react_bit30[0];
         4: events.apparent_bit30[1] <= ~events.apparent_bit30[1];
         5: events.line_cycle_done <= 1'b1;
         6, 7, 8: events.tot_act_sign[b-6] <= ~events.tot_act_sign[b-6];
         10, 11, 12: events.tot_react_sign[b-10] <= ~events.tot_react_sign[b-10];
         9, 13, 18: events.path_sum_sign[(b-9)/4] <= ~events.path_sum_sign[(b-9)/4];
         14, 15, 16: events.cal_pulse_raw_n[b-14] <= 1'b0;
         default: events.dsp_pass_done <= 1'b1;
      endcase
      @(posedge aclk);
      events.line_cycle_done <= 1'b0;
      events.dsp_pass_done <= 1'b0;
      @(posedge aclk);
      chk(32'({c3, c2, c1}), 32'h7, "disabled pulse outputs");
      events.cal_pulse_raw_n <= 3'h7;
      repeat (3) @(posedge aclk);
   endtask
   initial begin
      repeat (20000) @(posedge aclk);
      err_total++;
      test_done();
   end
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      chk(32'({irq, irq_n}), 32'h2, "reset-complete irq");
      rd(ST, d, r);
      chk(d, 32'h8000_0000, "reset-complete flag");
      wr(EN, 32'h0, r);
      rd(ST, d, r);
      chk(d, 32'h8000_0000, "flag not maskable");
      rd(EN, d, r);
      chk(d, MIE_RST_IRQ_ENABLE_FIRST, "mask reset");
      wr(EN, 32'hFFFF_FFFF, r);
      rd(EN, d, r);
      chk(d, 32'h0007_FFFF, "reserved bits");
      rd(20'h00010, d, r);
      chk(d, 32'h0, "unmapped read data");
      chk(32'(r), 32'(MIE_RESP_SLVERR), "unmapped read");
      wr(20'h00010, 32'h1, r);
      chk(32'(r), 32'(MIE_RESP_SLVERR), "unmapped write");
      wr(ST, 32'hFFFF_FFFF, r);
      repeat (2) @(posedge aclk);
      chk(32'(irq), 32'h0, "cleared");
      wr(PM, 32'h0000_0EEC, r);
      chk(32'({pulse_cfg.pulse_three_power_sel, pulse_cfg.pulse_two_power_sel,
         pulse_cfg.pulse_one_power_sel}), 32'h0EC, "power selectors");
      for (int b = 0; b < 19; b++) begin
         wr(EN, 32'h1 << b, r);
         ev(b);
         rd(ST, d, r);
         chk(d, 32'h1 << b, "status of event");
         chk(32'(irq), 32'h1, "enabled event irq");
         wr(ST, 32'h1 << b, r);
         wr(EN, ~(32'h1 << b), r);
         ev(b);
         chk(32'(irq), 32'h0, "masked event irq");
         rd(ST, d, r);
         chk(d, 32'h1 << b, "masked event recorded");
         wr(ST, 32'h1 << b, r);
      end
      // sign source switch may itself flag a change, so status is cleared after it
      wr(AM, 32'h0000_00C0, r);
      wr(EN, 32'h0000_0440, r);
      wr(ST, 32'hFFFF_FFFF, r);
      chk(32'({pulse_cfg.reactive_sign_source_sel, pulse_cfg.active_sign_source_sel}), 32'h3,
         "sign sources");
      @(posedge aclk);
      events.fund_act_sign[0] <= 1'b1;
      events.fund_react_sign[0] <= 1'b1;
      repeat (3) @(posedge aclk);
      chk(32'(irq), 32'h1, "fundamental sign irq");
      rd(ST, d, r);
      chk(d, 32'h0000_0440, "fundamental sign status");
      wr(PM, 32'h0, r);
      @(posedge aclk);
      events.cal_pulse_raw_n <= 3'h0;
      repeat (2) @(posedge aclk);
      chk(32'({c3, c2, c1}), 32'h0, "enabled pulse outputs");
      events.cal_pulse_raw_n <= 3'h7;
      repeat (2) @(posedge aclk);
      test_done();
   end
endmodule
